/* rtl/pwm_auto_reload_timer.sv */
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pwm_auto_reload_timer (
	input  wire logic                                clock,
	input  wire logic                                rst_n,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [pwm_art_pkg::ADDR_W-1:0]      paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic                                extClock,
	input  wire logic [pwm_art_pkg::NUM_CAP-1:0]     capturePin,
	input  wire logic                                haltMode,
	output logic      [pwm_art_pkg::NUM_PWM-1:0]     pwmOutputPin,
	output logic      [pwm_art_pkg::NUM_PWM-1:0]     pwmPinDrive,
	output logic                                     overflowIrq,
	output logic      [pwm_art_pkg::NUM_CAP-1:0]     captureIrq,
	output logic                                     wakeRequest
);
	localparam int NP = pwm_art_pkg::NUM_PWM;
	localparam int NC = pwm_art_pkg::NUM_CAP;

	typedef struct packed {
		logic [NC-1:0]        capSync1;
		logic [NC-1:0]        capSync2;
		logic [NC-1:0]        capPrev;
		logic                 extSync1;
		logic                 extSync2;
		logic                 extPrev;
		logic [6:0]           presc;
		logic [7:0]           cnt;
		logic [7:0]           reload;
		logic [7:0]           csr;
		logic [7:0]           pwmCtrl;
		logic [NP-1:0][7:0]   duty;
		logic [NP-1:0][7:0]   compareShadow;
		logic [NC-1:0]        edgeSel;
		logic [NC-1:0]        capIrqEnable;
		logic [NC-1:0]        captureFlag;
		logic [NC-1:0][7:0]   captureValue;
		logic [NP-1:0]        pwmPin;
		logic [NP-1:0]        pwmDrive;
		logic                 ovfIrq;
		logic [NC-1:0]        capIrq;
		logic                 wake;
		logic [7:0]           rdData;
		logic                 ready;
		logic                 slvErr;
	} state_t;

	state_t s_ff;
	state_t nxt_s;

	logic [pwm_art_pkg::IDX_W-1:0] idx;
	logic                          setup;
	logic                          access;
	logic                          wr;
	logic                          rd;
	logic                          inTick;
	logic                          cntTick;
	logic                          overflow;
	logic [6:0]                    mask;
	logic [2:0]                    cc;
	logic                          mapped;
	logic [7:0]                    rdMux;
	logic [NC-1:0]                 capEdge;
	logic [NC-1:0]                 capRead;

	assign idx    = paddr[pwm_art_pkg::ADDR_W-1:2];
	assign setup  = psel & ~penable;
	assign access = psel & penable & s_ff.ready;
	assign wr     = access & pwrite;
	assign rd     = access & ~pwrite;
	assign cc     = s_ff.csr[pwm_art_pkg::CSR_CC_LSB +: 3];

	always_comb begin
		mapped = 1'b1;
		case (idx)
			pwm_art_pkg::IDX_DUTY0:   rdMux = s_ff.duty[0];
			pwm_art_pkg::IDX_DUTY1:   rdMux = s_ff.duty[1];
			pwm_art_pkg::IDX_DUTY2:   rdMux = s_ff.duty[2];
			pwm_art_pkg::IDX_DUTY3:   rdMux = s_ff.duty[3];
			pwm_art_pkg::IDX_PWMCTRL: rdMux = s_ff.pwmCtrl;
			// [R9] force reload reads zero
			pwm_art_pkg::IDX_CSR:     rdMux = s_ff.csr & ~(8'h01 << pwm_art_pkg::CSR_FORCE_RELOAD);
			// [R12] live counter value
			pwm_art_pkg::IDX_CNT:     rdMux = s_ff.cnt;
			pwm_art_pkg::IDX_RELOAD:  rdMux = s_ff.reload;
			pwm_art_pkg::IDX_CAPCSR:  rdMux = {2'h0, s_ff.edgeSel, s_ff.capIrqEnable,
				s_ff.captureFlag};
			pwm_art_pkg::IDX_CAPV1:   rdMux = s_ff.captureValue[0];
			pwm_art_pkg::IDX_CAPV2:   rdMux = s_ff.captureValue[1];
			default: begin
				rdMux  = 8'h00;
				mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		nxt_s = s_ff;
		// [R22] two-stage synchronisers, edges from later stages
		nxt_s.capSync1 = capturePin;
		nxt_s.capSync2 = s_ff.capSync1;
		nxt_s.capPrev  = s_ff.capSync2;
		nxt_s.extSync1 = extClock;
		nxt_s.extSync2 = s_ff.extSync1;
		nxt_s.extPrev  = s_ff.extSync2;

		// [R6] prescaler input source
		inTick = s_ff.csr[pwm_art_pkg::CSR_EXT_CLOCK_SELECT] ? (s_ff.extSync2 & ~s_ff.extPrev) : 1'b1;
		// [R7] tap of the prescaler picks 2^cc
		mask     = 7'((8'h01 << cc) - 8'h01);
		cntTick  = 1'b0;
		// [R8] run bit gates both stages
		if (s_ff.csr[pwm_art_pkg::CSR_TCE] && inTick) begin
			cntTick     = ((s_ff.presc & mask) == mask);
			nxt_s.presc = s_ff.presc + 7'h01;
		end
		overflow = cntTick && (s_ff.cnt == pwm_art_pkg::CNT_TOP);
		if (cntTick) begin
			// [R13] rollover reloads counter
			nxt_s.cnt = overflow ? s_ff.reload : s_ff.cnt + 8'h01;
		end
		if (overflow) begin
			// [R20] double-buffered duty, glitch free
			nxt_s.compareShadow = s_ff.duty;
		end

		// register writes; software access beats counting
		if (wr) begin
			case (idx)
				pwm_art_pkg::IDX_DUTY0:   nxt_s.duty[0] = pwdata[7:0];
				pwm_art_pkg::IDX_DUTY1:   nxt_s.duty[1] = pwdata[7:0];
				pwm_art_pkg::IDX_DUTY2:   nxt_s.duty[2] = pwdata[7:0];
				pwm_art_pkg::IDX_DUTY3:   nxt_s.duty[3] = pwdata[7:0];
				pwm_art_pkg::IDX_PWMCTRL: nxt_s.pwmCtrl = pwdata[7:0];
				pwm_art_pkg::IDX_CSR: begin
					// overflow flag and force bit are not stored from software
					nxt_s.csr = {pwdata[7:3], 1'b0, pwdata[pwm_art_pkg::CSR_OIE],
						s_ff.csr[pwm_art_pkg::CSR_OVF]};
					// [R9] force reload
					if (pwdata[pwm_art_pkg::CSR_FORCE_RELOAD]) begin
						nxt_s.cnt   = s_ff.reload;
						nxt_s.presc = 7'h00;
					end
				end
				pwm_art_pkg::IDX_CNT: begin
					// [R12] on-the-fly write restarts prescaler
					nxt_s.cnt   = pwdata[7:0];
					nxt_s.presc = 7'h00;
				end
				pwm_art_pkg::IDX_RELOAD:  nxt_s.reload = pwdata[7:0];
				pwm_art_pkg::IDX_CAPCSR: begin
					// [R4] edge choice and enables per channel
					nxt_s.edgeSel      = pwdata[pwm_art_pkg::CAP_CS_LSB +: NC];
					nxt_s.capIrqEnable = pwdata[pwm_art_pkg::CAP_IE_LSB +: NC];
				end
				default: begin
				end
			endcase
		end

		// [R11] read clears, a same-cycle overflow still sets
		if (rd && idx == pwm_art_pkg::IDX_CSR) begin
			nxt_s.csr[pwm_art_pkg::CSR_OVF] = 1'b0;
		end
		if (overflow) begin
			nxt_s.csr[pwm_art_pkg::CSR_OVF] = 1'b1;
		end

		capRead[0] = rd && idx == pwm_art_pkg::IDX_CAPV1;
		capRead[1] = rd && idx == pwm_art_pkg::IDX_CAPV2;
		for (int c = 0; c < NC; c++) begin
			// [R21] 1 rising, 0 falling
			capEdge[c] = s_ff.edgeSel[c] ? (s_ff.capSync2[c] & ~s_ff.capPrev[c])
				: (~s_ff.capSync2[c] & s_ff.capPrev[c]);
			// [R2] read releases the lock
			if (capRead[c]) begin
				nxt_s.captureFlag[c] = 1'b0;
			end
			// [R1] latch counter state; [R19] counter clock resolution
			if (capEdge[c] && (!s_ff.captureFlag[c] || capRead[c])) begin
				nxt_s.captureValue[c] = s_ff.cnt;
				nxt_s.captureFlag[c]  = 1'b1;
			end
		end

		for (int p = 0; p < NP; p++) begin
			// [R15] [R16] [R17] level from shadow compare and live polarity
			nxt_s.pwmPin[p] = nxt_s.pwmCtrl[pwm_art_pkg::PWM_OE_LSB + p]
				& ((nxt_s.cnt <= nxt_s.compareShadow[p])
				^ nxt_s.pwmCtrl[pwm_art_pkg::PWM_OP_LSB + p]);
			// [R14] pin handed to the channel
			nxt_s.pwmDrive[p] = nxt_s.pwmCtrl[pwm_art_pkg::PWM_OE_LSB + p];
		end

		// [R10] gated overflow request
		nxt_s.ovfIrq = nxt_s.csr[pwm_art_pkg::CSR_OVF] & nxt_s.csr[pwm_art_pkg::CSR_OIE];
		// [R3] pending while flag stays set
		nxt_s.capIrq = nxt_s.captureFlag & nxt_s.capIrqEnable;
		// [R5] wake from halt on any enabled request
		nxt_s.wake   = haltMode & ((|nxt_s.capIrq) | nxt_s.ovfIrq);

		// answer registered in setup, so one access cycle per transfer
		nxt_s.ready  = setup;
		nxt_s.slvErr = setup & ~mapped;
		nxt_s.rdData = setup ? rdMux : 8'h00;
	end

	always_ff @(posedge clock) begin
		// [R18] everything clears
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata       = {24'h000000, s_ff.rdData};
	assign pready       = s_ff.ready;
	assign pslverr      = s_ff.slvErr;
	assign pwmOutputPin = s_ff.pwmPin;
	assign pwmPinDrive  = s_ff.pwmDrive;
	assign overflowIrq  = s_ff.ovfIrq;
	assign captureIrq   = s_ff.capIrq;
	assign wakeRequest  = s_ff.wake;
endmodule
`default_nettype wire

/* pkg/pwm_art_pkg.sv */
// Behaviour
// [R1] capture edge latches counter, sets capture flag
// [R2] capture locked until value read; read clears
// [R3] capture irq held while flag and enable
// [R4] per-channel edge select and irq enable
// [R5] enabled edge irq wakes core in halt
// [R6] clock select: cpu clock or external clock
// [R7] prescaler divides by two to the field
// [R8] run bit 0 freezes prescaler and counter
// [R9] force reload: write-only, loads reload, clears prescaler
// [R10] overflow irq enable gates overflow request
// [R11] overflow on FFh rollover; status read clears
// [R12] counter access reads/writes live counter
// [R13] overflow reloads counter and switches pwm levels
// [R14] output enable connects channel to pin
// [R15] output high while counter at most compare
// [R16] polarity change inverts output immediately
// [R17] duty sets second edge; reload first edge
// [R18] all registers zero after reset
// [R19] capture resolution is one counter clock
// [R20] compare shadow reloaded from duty on overflow
// [R21] edge select 1 rising, 0 falling
// [R22] capture inputs synchronised before edge detection
package pwm_art_pkg;
	localparam int ADDR_W     = 12;
	localparam int IDX_W      = 10;
	localparam int NUM_PWM    = 4;
	localparam int NUM_CAP    = 2;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_DUTY3   = 10'h073;
	localparam logic [IDX_W-1:0] IDX_DUTY2   = 10'h074;
	localparam logic [IDX_W-1:0] IDX_DUTY1   = 10'h075;
	localparam logic [IDX_W-1:0] IDX_DUTY0   = 10'h076;
	localparam logic [IDX_W-1:0] IDX_PWMCTRL = 10'h077;
	localparam logic [IDX_W-1:0] IDX_CSR     = 10'h078;
	localparam logic [IDX_W-1:0] IDX_CNT     = 10'h079;
	localparam logic [IDX_W-1:0] IDX_RELOAD  = 10'h07a;
	localparam logic [IDX_W-1:0] IDX_CAPCSR  = 10'h07b;
	localparam logic [IDX_W-1:0] IDX_CAPV1   = 10'h07c;
	localparam logic [IDX_W-1:0] IDX_CAPV2   = 10'h07d;
	// timer_control_status fields
	localparam int CSR_EXT_CLOCK_SELECT   = 7;
	localparam int CSR_CC_LSB = 4;
	localparam int CSR_TCE    = 3;
	localparam int CSR_FORCE_RELOAD   = 2;
	localparam int CSR_OIE    = 1;
	localparam int CSR_OVF    = 0;
	// pwm_output_control fields
	localparam int PWM_OE_LSB = 4;
	localparam int PWM_OP_LSB = 0;
	// capture_ctrl_status fields
	localparam int CAP_CS_LSB = 4;
	localparam int CAP_IE_LSB = 2;
	localparam int CAP_CF_LSB = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CNT_TOP   = 8'hff;
endpackage

/* testbench/pwm_art_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_art_assertions (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        haltMode,
	input wire logic [3:0]  pwmOutputPin,
	input wire logic [3:0]  pwmPinDrive,
	input wire logic        overflowIrq,
	input wire logic [1:0]  captureIrq,
	input wire logic        wakeRequest
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic [9:0] idx;
	logic       wr;
	assign idx = paddr[11:2];
	assign wr = psel && penable && pready && pwrite;
	a_ready_after_setup: assert property (psel && !penable |=> pready && !$past(pready))
		else $error("ready missing after setup");
	a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_unmapped_error: assert property (pready |-> pslverr == !(idx inside {[10'h073:10'h07d]}))
		else $error("error response wrong");
	a_reload_reads_zero: assert property (pready && !pwrite && idx == pwm_art_pkg::IDX_CSR |-> !prdata[2])
		else $error("force reload bit read back");
	a_pin_needs_enable: assert property ((pwmOutputPin & ~pwmPinDrive) == 4'h0)
		else $error("disabled pin driven");
	a_ovf_irq_gated: assert property (wr && idx == pwm_art_pkg::IDX_CSR && !pwdata[1] |=> ##1 !overflowIrq)
		else $error("overflow irq while disabled");
	a_cap_irq_gated: assert property (wr && idx == pwm_art_pkg::IDX_CAPCSR |=> ##1 (captureIrq & ~$past(pwdata[3:2], 2)) == 2'h0)
		else $error("capture irq while disabled");
	a_wake_needs_halt: assert property (!haltMode [*2] |-> !wakeRequest)
		else $error("wake outside halt");
	a_reset_quiet: assert property ($rose(rst_n) |-> pwmOutputPin == 4'h0 && !overflowIrq && captureIrq == 2'h0)
		else $error("outputs active after reset");
	cover property (overflowIrq);
	cover property (captureIrq[0]);
	cover property (wakeRequest);
	cover property (pslverr);
endmodule
bind pwm_auto_reload_timer pwm_art_assertions pwm_art_assertions_inst (.clock(clock), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .haltMode(haltMode),
	.pwmOutputPin(pwmOutputPin), .pwmPinDrive(pwmPinDrive), .overflowIrq(overflowIrq),
	.captureIrq(captureIrq), .wakeRequest(wakeRequest));
`default_nettype wire

/* testbench/pwm_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side (
	input wire logic  clock,
	output logic [1:0] capturePin,
	output logic       extClock
);
	initial begin
		capturePin = 2'h0;
		extClock = 1'h0;
	end
	// levels held 4 clocks so the input synchroniser never misses an edge
	task automatic toggle(input int ch);
		capturePin[ch] <= ~capturePin[ch];
		repeat (4) @(posedge clock);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clock) extClock <= 1'h1;
			repeat (3) @(posedge clock);
			extClock <= 1'h0;
			repeat (4) @(posedge clock);
		end
	endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, haltMode, extClock, err;
	logic        overflowIrq, wakeRequest;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pwmOutputPin, pwmPinDrive, pol;
	logic [1:0]  capturePin, captureIrq;
	logic [7:0]  duty [4];
	logic [7:0]  c, v;
	int          err_total = 0, samples_checked = 0, cycles = 0;
	pwm_auto_reload_timer pwm_auto_reload_timer_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .extClock(extClock), .capturePin(capturePin),
		.haltMode(haltMode), .pwmOutputPin(pwmOutputPin), .pwmPinDrive(pwmPinDrive),
		.overflowIrq(overflowIrq), .captureIrq(captureIrq), .wakeRequest(wakeRequest));
	pwm_far_side pwm_far_side_inst (.clock(clock), .capturePin(capturePin), .extClock(extClock));
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		int n = 0;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdchk(input logic [9:0] i, input logic [7:0] e);
		apb(1'h0, i, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	function automatic logic [3:0] pins(input logic [7:0] cnt, input logic [3:0] p);
		for (int k = 0; k < 4; k++)
			pins[k] = (cnt <= duty[k]) ^ p[k];
	endfunction
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, haltMode} = '0;
		rst_n = 1'h0;
		void'($urandom(70));
		repeat (8) @(posedge clock);
		rst_n <= 1'h1;
		for (int i = 'h73; i <= 'h7d; i++)
			rdchk(i[9:0], 8'h00);
		apb(1'h0, 10'h000, 8'h00);
		chk(32'(err), 32'h1);
		for (int i = 0; i < 4; i++) begin
			duty[i] = 8'($urandom);
			apb(1'h1, pwm_art_pkg::IDX_DUTY0 - i[9:0], duty[i]);
		end
		v = 8'($urandom % 200);
		apb(1'h1, pwm_art_pkg::IDX_RELOAD, v);
		rdchk(pwm_art_pkg::IDX_RELOAD, v);
		apb(1'h1, pwm_art_pkg::IDX_CNT, 8'hfd);
		apb(1'h1, pwm_art_pkg::IDX_CSR, 8'h0a);
		for (int n = 0; n < 20 && overflowIrq !== 1'h1; n++)
			@(posedge clock);
		apb(1'h1, pwm_art_pkg::IDX_CSR, 8'h02);
		rdchk(pwm_art_pkg::IDX_CSR, 8'h03);
		rdchk(pwm_art_pkg::IDX_CSR, 8'h02);
		chk(32'(overflowIrq), 32'h0);
		apb(1'h0, pwm_art_pkg::IDX_CNT, 8'h00);
		chk(32'(rd[7:0] - v < 8'h10), 32'h1);
		rdchk(pwm_art_pkg::IDX_CNT, rd[7:0]);
		apb(1'h1, pwm_art_pkg::IDX_CNT, 8'h33);
		apb(1'h1, pwm_art_pkg::IDX_CSR, 8'h04);
		rdchk(pwm_art_pkg::IDX_CNT, v);
		rdchk(pwm_art_pkg::IDX_CSR, 8'h00);
		// an overflow is needed before the new duty values reach the compare
		apb(1'h1, pwm_art_pkg::IDX_CNT, 8'hff);
		apb(1'h1, pwm_art_pkg::IDX_CSR, 8'h08);
		apb(1'h1, pwm_art_pkg::IDX_CSR, 8'h00);
		c = duty[2];
		pol = 4'($urandom);
		apb(1'h1, pwm_art_pkg::IDX_CNT, c);
		rdchk(pwm_art_pkg::IDX_CNT, c);
		apb(1'h1, pwm_art_pkg::IDX_PWMCTRL, {4'hf, pol});
		@(posedge clock);
		chk(32'(pwmOutputPin), 32'(pins(c, pol)));
		chk(32'(pwmPinDrive), 32'hf);
		apb(1'h1, pwm_art_pkg::IDX_PWMCTRL, {4'h5, ~pol});
		@(posedge clock);
		chk(32'(pwmOutputPin), 32'(pins(c, ~pol) & 4'h5));
		apb(1'h1, pwm_art_pkg::IDX_DUTY2, ~duty[2]);
		@(posedge clock);
		chk(32'(pwmOutputPin), 32'(pins(c, ~pol) & 4'h5));
		apb(1'h1, pwm_art_pkg::IDX_CAPCSR, 8'h1c);
		pwm_far_side_inst.toggle(0);
		repeat (2) @(posedge clock);
		chk(32'(captureIrq), 32'h1);
		haltMode <= 1'h1;
		repeat (3) @(posedge clock);
		chk(32'(wakeRequest), 32'h1);
		haltMode <= 1'h0;
		rdchk(pwm_art_pkg::IDX_CAPCSR, 8'h1d);
		apb(1'h1, pwm_art_pkg::IDX_CNT, c + 8'h01);
		pwm_far_side_inst.toggle(0);
		pwm_far_side_inst.toggle(0);
		rdchk(pwm_art_pkg::IDX_CAPV1, c);
		rdchk(pwm_art_pkg::IDX_CAPCSR, 8'h1c);
		pwm_far_side_inst.toggle(1);
		pwm_far_side_inst.toggle(1);
		rdchk(pwm_art_pkg::IDX_CAPV2, c + 8'h01);
		for (int n = 0; n < 3; n++) begin
			apb(1'h1, pwm_art_pkg::IDX_CNT, 8'h10);
			apb(1'h1, pwm_art_pkg::IDX_CSR, {1'h1, n[2:0], 4'h8});
			pwm_far_side_inst.ticks(3 << n);
			repeat (4) @(posedge clock);
			apb(1'h1, pwm_art_pkg::IDX_CSR, 8'h80);
			rdchk(pwm_art_pkg::IDX_CNT, 8'h13);
		end
		// reset again with registers dirty: everything must clear
		rst_n <= 1'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		rdchk(pwm_art_pkg::IDX_CNT, 8'h00);
		rdchk(pwm_art_pkg::IDX_CSR, 8'h00);
		rdchk(pwm_art_pkg::IDX_CAPCSR, 8'h00);
		chk(32'(pwmPinDrive), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
